// >>> image_checksum.sv
// host-side checksum engine reading a device image over a byte read port
//
// Function
// - configuration bytes are fetched from image address 300000h onward.
// - data eeprom lives at image address f00000h and is never fetched here.
// - only the low sixteen bits of the sum are kept; carries are dropped.
// - data eeprom bytes never enter the sum.
// - every 16-bit program word from 000000h to the last block end is added.
// - each configuration byte is anded with its own mask before adding.
// - the id field carries the unprotected sum in its upper half, lower half clear.
// - the id value is program sum plus masked configuration bytes, without id words.
// - id location words are added only when some block is protected.
// - block ends are 0007ff, 001fff, 003fff, 005fff and 007fff.
`timescale 1ns/1ps
module image_checksum
  import chk_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic start,
  output logic busy,
  output logic done,
  // memory read port towards the programming link
  output rd_cmd_t rd_cmd,
  input wire rd_rsp_t rd_rsp,
  // results
  output logic [15:0] checksum,
  output logic [31:0] id_field,
  output logic any_prot
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_CFG, S_PM, S_ID, S_DONE} st_t;

  st_t st_r, st_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [15:0] acc_r, acc_nxt;
  logic [15:0] pre_r, pre_nxt;
  logic [7:0] lo_r, lo_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic prot_r, prot_nxt;
  logic req_r, req_nxt;
  logic done_r, done_nxt;
  logic busy_r, busy_nxt;
  logic [15:0] sum_r, sum_nxt;
  logic [31:0] idf_r, idf_nxt;
  logic [7:0] cfg_term;
  logic take;
  logic [15:0] word;

  cfg_mask_unit u_mask (
    .idx(idx_r),
    .raw(rd_rsp.data),
    .masked(cfg_term)
  );

  assign take = req_r && rd_rsp.ack;
  assign word = {rd_rsp.data, lo_r};

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    addr_nxt = addr_r;
    acc_nxt = acc_r;
    pre_nxt = pre_r;
    lo_nxt = lo_r;
    idx_nxt = idx_r;
    prot_nxt = prot_r;
    req_nxt = req_r;
    done_nxt = done_r;
    busy_nxt = busy_r;
    sum_nxt = sum_r;
    idf_nxt = idf_r;
    case (st_r)
      S_IDLE, S_DONE: begin
        if (start) begin
          acc_nxt = 16'h0000;
          pre_nxt = 16'h0000;
          prot_nxt = 1'b0;
          idx_nxt = 4'h0;
          addr_nxt = CFG_BASE;
          req_nxt = 1'b1;
          done_nxt = 1'b0;
          busy_nxt = 1'b1;
          st_nxt = S_CFG;
        end
      end
      S_CFG: begin
        // configuration is fetched first so protection is known before id words
        if (take) begin
          acc_nxt = 16'(acc_r + {8'h00, cfg_term});
          pre_nxt = 16'(pre_r + {8'h00, cfg_term});
          // unimplemented protect bits read as ones and so look unprotected
          if (idx_r == CP_IDX &&
              (rd_resp_data_and(rd_rsp.data) != CP_BLK_MASK)) begin
            prot_nxt = 1'b1;
          end
          if (idx_r == CPB_IDX && !rd_rsp.data[CPB_BIT]) begin
            prot_nxt = 1'b1;
          end
          if (idx_r == CFG_LAST) begin
            addr_nxt = PM_BASE;
            st_nxt = S_PM;
          end else begin
            idx_nxt = 4'(idx_r + 4'h1);
            addr_nxt = 24'(addr_r + 24'h1);
          end
        end
      end
      S_PM: begin
        if (take) begin
          if (!addr_r[0]) begin
            lo_nxt = rd_rsp.data;
          end else begin
            // protected blocks arrive as zero words and change nothing
            acc_nxt = 16'(acc_r + word);
            pre_nxt = 16'(pre_r + word);
          end
          if (addr_r == PM_END) begin
            if (prot_r) begin
              addr_nxt = ID_BASE;
              st_nxt = S_ID;
            end else begin
              req_nxt = 1'b0;
              busy_nxt = 1'b0;
              done_nxt = 1'b1;
              sum_nxt = 16'(acc_r + word);
              idf_nxt = {16'(pre_r + word), ID_LOW_CLEAR};
              st_nxt = S_DONE;
            end
          end else begin
            addr_nxt = 24'(addr_r + 24'h1);
          end
        end
      end
      S_ID: begin
        if (take) begin
          if (!addr_r[0]) begin
            lo_nxt = rd_rsp.data;
          end else begin
            acc_nxt = 16'(acc_r + word);
          end
          if (addr_r == ID_LAST) begin
            req_nxt = 1'b0;
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
            sum_nxt = 16'(acc_r + word);
            idf_nxt = {pre_r, ID_LOW_CLEAR};
            st_nxt = S_DONE;
          end else begin
            addr_nxt = 24'(addr_r + 24'h1);
          end
        end
      end
      default: begin
        st_nxt = S_IDLE;
        req_nxt = 1'b0;
        busy_nxt = 1'b0;
      end
    endcase
  end

  function automatic logic [7:0] rd_resp_data_and(input logic [7:0] d);
    rd_resp_data_and = d & CP_BLK_MASK;
  endfunction : rd_resp_data_and

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= S_IDLE;
      addr_r <= 24'h000000;
      acc_r <= 16'h0000;
      pre_r <= 16'h0000;
      lo_r <= 8'h00;
      idx_r <= 4'h0;
      prot_r <= 1'b0;
      req_r <= 1'b0;
      done_r <= 1'b0;
      busy_r <= 1'b0;
      sum_r <= 16'h0000;
      idf_r <= 32'h00000000;
    end else begin
      st_r <= st_nxt;
      addr_r <= addr_nxt;
      acc_r <= acc_nxt;
      pre_r <= pre_nxt;
      lo_r <= lo_nxt;
      idx_r <= idx_nxt;
      prot_r <= prot_nxt;
      req_r <= req_nxt;
      done_r <= done_nxt;
      busy_r <= busy_nxt;
      sum_r <= sum_nxt;
      idf_r <= idf_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rd_cmd.req = req_r;
  assign rd_cmd.addr = addr_r;
  assign busy = busy_r;
  assign done = done_r;
  assign checksum = sum_r;
  assign id_field = idf_r;
  assign any_prot = prot_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_start_taken;
    start && (st_r == S_IDLE || st_r == S_DONE);
  endsequence

  sequence s_first_cfg;
    req_r && addr_r == CFG_BASE && acc_r == 16'h0000 && !done_r;
  endsequence

  a_start_clears_sum: assert property (s_start_taken |=> s_first_cfg)
    else $error("start did not clear sum and fetch first config byte");

  a_done_holds_sum: assert property (done_r && !start |=> done_r && $stable(sum_r))
    else $error("result not held until next start");

  a_cfg_addr_window: assert property (st_r == S_CFG |-> addr_r == CFG_BASE + {20'h0, idx_r})
    else $error("config fetch outside its image window");

  a_no_eeprom_fetch: assert property (req_r |-> addr_r[23:20] != EE_TOP_NIB)
    else $error("data eeprom address requested");

  a_pm_range_end: assert property (st_r == S_PM |-> addr_r <= PM_END)
    else $error("program fetch past last block end");

  a_cfg_masked_add: assert property (st_r == S_CFG && take |=>
      acc_r == 16'($past(acc_r) + {8'h00, ($past(rd_rsp.data) & CFG_MASK[$past(idx_r)])}))
    else $error("config byte not masked into sum");

  a_pm_word_add: assert property (st_r == S_PM && take && addr_r[0] && addr_r != PM_END |=>
      acc_r == 16'($past(acc_r) + {$past(rd_rsp.data), $past(lo_r)}))
    else $error("program word not added high:low");

  a_id_only_protected: assert property (st_r == S_ID |-> prot_r)
    else $error("id words fetched with no block protected");

  a_id_field_form: assert property ($rose(done_r) |-> id_field[15:0] == ID_LOW_CLEAR &&
      (prot_r || id_field[31:16] == sum_r))
    else $error("id field not unprotected sum over clear low half");

endmodule : image_checksum

// >>> chk_pkg.sv
// constants and carrier types for the image checksum engine
package chk_pkg;

  // ----------------------------------------------------------------
  // image address map
  // ----------------------------------------------------------------
  localparam logic [23:0] PM_BASE = 24'h000000;
  localparam logic [23:0] ID_BASE = 24'h200000;
  localparam logic [23:0] CFG_BASE = 24'h300000;
  localparam logic [23:0] EE_BASE = 24'hf00000;
  localparam logic [3:0] EE_TOP_NIB = 4'hf;

  // block end addresses of the 32 kbyte, four-block part
  localparam logic [23:0] BOOT_END = 24'h0007ff;
  localparam logic [23:0] BLK0_END = 24'h001fff;
  localparam logic [23:0] BLK1_END = 24'h003fff;
  localparam logic [23:0] BLK2_END = 24'h005fff;
  localparam logic [23:0] BLK3_END = 24'h007fff;
  localparam logic [23:0] PM_END = BLK3_END;

  // ----------------------------------------------------------------
  // configuration bytes and id locations
  // ----------------------------------------------------------------
  localparam int CFG_COUNT = 14;
  localparam logic [3:0] CFG_LAST = 4'hd;
  localparam logic [23:0] ID_LAST = 24'h200007;
  localparam logic [3:0] CP_IDX = 4'h8;
  localparam logic [3:0] CPB_IDX = 4'h9;
  localparam logic [7:0] CP_BLK_MASK = 8'h0f;
  localparam int CPB_BIT = 6;
  localparam logic [15:0] ID_LOW_CLEAR = 16'h0000;

  // per-byte masks, index 0 is the byte at the configuration base
  localparam logic [7:0] CFG_MASK [CFG_COUNT] = '{
    8'h00, 8'hcf, 8'h1f, 8'h1f, 8'h00, 8'h87, 8'hc5,
    8'h00, 8'h0f, 8'hc0, 8'h0f, 8'he0, 8'h0f, 8'h40
  };

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic req;
    logic [23:0] addr;
  } rd_cmd_t;

  typedef struct packed {
    logic ack;
    logic [7:0] data;
  } rd_rsp_t;

endpackage : chk_pkg

// >>> cfg_mask_unit.sv
// masks one configuration byte by its position
`timescale 1ns/1ps
module cfg_mask_unit
  import chk_pkg::*;
(
  // selection
  input wire logic [3:0] idx,
  input wire logic [7:0] raw,
  // result
  output logic [7:0] masked
);

  logic [7:0] term [CFG_COUNT];

  // one term per mask entry; only the selected entry is non-zero
  genvar i;
  generate
    for (i = 0; i < CFG_COUNT; i++) begin : g_mask
      assign term[i] = (idx == 4'(i)) ? (raw & CFG_MASK[i]) : 8'h00;
    end
  endgenerate

  always_comb begin
    masked = 8'h00;
    for (int k = 0; k < CFG_COUNT; k++) begin
      masked = masked | term[k];
    end
  end

endmodule : cfg_mask_unit

// >>> dev_read_model.sv
// read-side model of the device behind the programming link
`timescale 1ns/1ps
module dev_read_model
  import chk_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // link
  input wire rd_cmd_t rd_cmd,
  output rd_rsp_t rd_rsp,
  // device settings, protect bits are active low
  input wire logic slow,
  input wire logic [3:0] cp_n,
  input wire logic cpb_n
);
  logic ph_r;
  logic [7:0] pat;
  logic prot;
  logic go;

  // stall every other cycle outside program memory when slow
  always_ff @(posedge clk) ph_r <= sys_rst ? 1'b0 : ~ph_r;

  always_comb begin
    pat = 8'h3c + 8'h11 * rd_cmd.addr[7:0];
    if (rd_cmd.addr[3:0] == CP_IDX) pat[3:0] = cp_n;
    if (rd_cmd.addr[3:0] == CPB_IDX) pat[CPB_BIT] = cpb_n;
    prot = rd_cmd.addr <= BOOT_END ? ~cpb_n : rd_cmd.addr <= BLK0_END ? ~cp_n[0] :
           rd_cmd.addr <= BLK1_END ? ~cp_n[1] : rd_cmd.addr <= BLK2_END ? ~cp_n[2] :
           ~cp_n[3];
    go = rd_cmd.req & ~(slow & ph_r & (rd_cmd.addr[23:20] != 4'h0));
    rd_rsp.ack = go;
    // idle data is scrambled so a stale byte is never mistaken for a fresh one
    if (!go) rd_rsp.data = ~rd_cmd.addr[7:0];
    else if (rd_cmd.addr[23:20] == 4'h3) rd_rsp.data = pat | ~CFG_MASK[rd_cmd.addr[3:0]];
    else if (rd_cmd.addr[23:20] == 4'h2) rd_rsp.data = rd_cmd.addr[7:0] + 8'h11;
    else if (rd_cmd.addr[23:20] == EE_TOP_NIB) rd_rsp.data = 8'hee;
    else if (prot) rd_rsp.data = 8'h00;
    else rd_rsp.data = rd_cmd.addr[7:0] ^ rd_cmd.addr[15:8];
  end
endmodule : dev_read_model

// >>> image_checksum_tb.sv
// self-checking bench for the image checksum engine
`timescale 1ns/1ps
module image_checksum_tb
  import chk_pkg::*;
;
  logic clk, sys_rst, start, busy, done, any_prot, slow, cpb_n;
  logic [3:0] cp_n;
  rd_cmd_t rd_cmd;
  rd_rsp_t rd_rsp;
  logic [15:0] checksum;
  logic [31:0] id_field;
  logic ee_seen = 1'b0;
  int n_mismatch = 0;
  int check_count = 0;

  image_checksum i_image_checksum (.clk(clk), .sys_rst(sys_rst), .start(start), .busy(busy),
    .done(done), .rd_cmd(rd_cmd), .rd_rsp(rd_rsp), .checksum(checksum),
    .id_field(id_field), .any_prot(any_prot));
  dev_read_model i_dev_read_model (.clk(clk), .sys_rst(sys_rst), .rd_cmd(rd_cmd),
    .rd_rsp(rd_rsp), .slow(slow), .cp_n(cp_n), .cpb_n(cpb_n));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) if (rd_cmd.req && rd_cmd.addr[23:20] == EE_TOP_NIB) ee_seen <= 1'b1;

  // wide enough for the reset snapshot of all outputs except rd_cmd.addr in one compare
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // ------------------------------------------------------------
  // expected sum, kept 16 bits wide so carries fall away
  // ------------------------------------------------------------
  function automatic logic [15:0] exp_sum(input logic [3:0] cp, input logic cpb,
                                          input logic idw);
    logic [15:0] s;
    logic [7:0] p;
    logic [23:0] a;
    s = 16'h0000;
    for (int i = 0; i < CFG_COUNT; i++) begin
      p = 8'h3c + 8'h11 * i[7:0];
      if (i == 8) p[3:0] = cp;
      if (i == 9) p[6] = cpb;
      s += {8'h00, p & CFG_MASK[i]};
    end
    for (int w = 0; w < 16384; w++) begin
      a = 24'(2 * w);
      if (!(a <= BOOT_END ? ~cpb : a <= BLK0_END ? ~cp[0] : a <= BLK1_END ? ~cp[1] :
            a <= BLK2_END ? ~cp[2] : ~cp[3]))
        s += {a[7:0] ^ a[15:8] ^ 8'h01, a[7:0] ^ a[15:8]};
    end
    for (int k = 0; k < 4; k++)
      if (idw) s += {8'h12 + 8'(2 * k), 8'h11 + 8'(2 * k)};
    return s;
  endfunction : exp_sum

  // ------------------------------------------------------------
  // one full run with given protection and ack pace
  // ------------------------------------------------------------
  task automatic run_case(input string tag, input logic [3:0] cp, input logic cpb,
                          input logic sl);
    int n;
    logic p;
    p = (cp != 4'hf) | ~cpb;
    cp_n = cp;
    cpb_n = cpb;
    slow = sl;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    chk("busy", busy, 1'b1);
    chk("first addr", rd_cmd.addr, CFG_BASE);
    repeat (100) @(negedge clk);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    chk("start ignored", rd_cmd.addr == CFG_BASE, 1'b0);
    n = 0;
    // one run is about 33k byte reads, so this limit only trips on a hang
    while (done !== 1'b1 && n < 40000) begin
      @(negedge clk);
      n++;
    end
    chk("done", {busy, done, rd_cmd.req}, 3'b010);
    chk("any_prot", any_prot, p);
    chk("checksum", checksum, exp_sum(cp, cpb, p));
    chk("id_field", id_field, {exp_sum(cp, cpb, 1'b0), ID_LOW_CLEAR});
    repeat (5) @(negedge clk);
    chk("held", {done, checksum}, {1'b1, exp_sum(cp, cpb, p)});
    chk("eeprom", ee_seen, 1'b0);
    $display("test %s finished", tag);
  endtask : run_case

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  initial begin
    // two runs of about 33k cycles each, plus margin
    #1_500_000;
    n_mismatch++;
    close_out();
  end

  initial begin
    sys_rst = 1'b1;
    start = 1'b0;
    slow = 1'b0;
    cp_n = 4'hf;
    cpb_n = 1'b1;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    chk("reset outs", {busy, done, any_prot, rd_cmd.req, checksum, id_field}, '0);
    run_case("plain", 4'hf, 1'b1, 1'b0);
    // boot and block 2 protected, slow acks, restart tried mid run
    run_case("protected", 4'b1011, 1'b0, 1'b1);
    close_out();
  end
endmodule : image_checksum_tb
